// [rtl/ipn_priority_gate_unit.v]
// Interrupt priority gate unit: per-source levels, mask gating, mask history.
// Assumes peripheral flags and enables synchronous to MCLK, and a CPU that
// pulses VEC_FETCH for one cycle with the serviced vector number.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ipn_regs.vh"

// Contract
// - Two-bit level per source, three highest
// - Levels readable and writable at any time
// - Enabled: pass request when level at least mask
// - Deep stop compares against zero mask
// - Disabled: requests forwarded unchanged
// - CPU keeps its own fixed vector arbitration
// - Vector fetch loads mask with serviced level
// - Fetch pushes previous mask, four deep history
// - Software may overwrite mask, except in a fetch cycle or a write with the restore strobe set
// - Lower levels blocked, equal or higher preempt
// - Conversion flag with enable raises vector 22
// - Clock loss with monitor enable resets
// - Request sent only when local enable set
// - Restore strobe pops last saved mask
// - Full and empty flags track history
// - Mask in two low control bits
module ipn_priority_gate_unit (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Peripheral sources, indexed by vector number
  input wire [39:0] SRC_FLAG,
  input wire [39:0] SRC_EN,
  input wire CONV_DONE_FLAG,
  // CPU side
  input wire DEEP_STOP,
  input wire VEC_FETCH,
  input wire [5:0] VEC_NUM,
  output reg [39:0] GATED_REQ,
  output reg [15:0] VEC_ADDR,
  // Reset causes
  input wire CLK_LOSS,
  input wire [6:0] RST_EVENTS,
  output reg RESET_REQ,
  // Interrupt
  output reg IRQ
);

  // Mask, history and control state
  reg [1:0] priority_mask;
  reg [79:0] source_priority_level;
  reg [7:0] mask_history_stack;
  reg [2:0] hist_cnt;
  reg history_full_flag;
  reg history_empty_flag;
  reg ctrl_enable;
  reg conversion_irq_enable;
  reg clock_monitor_enable;
  reg [`IPN_EV_W-1:0] irq_status;
  reg [`IPN_EV_W-1:0] irq_mask;

  // Combinational next values
  reg [39:0] next_gated;
  reg [31:0] next_rdata;
  reg next_slverr;
  reg [39:0] req;
  integer i;

  // Vector numbers past the last source read as level zero
  function [1:0] level_of;
    input [79:0] lv;
    input [5:0] idx;
    begin
      if (idx < `IPN_SRC_N) begin
        level_of = lv[idx*2 +: 2];
      end else begin
        level_of = 2'b00;
      end
    end
  endfunction

  // Handler high byte sits at the lower address of the pair
  function [15:0] vec_loc;
    input [5:0] n;
    begin
      vec_loc = `IPN_VEC_TOP - {9'h000, n, 1'b0};
    end
  endfunction

  wire access = PSEL & PENABLE & PREADY;
  wire wr = access & PWRITE;
  wire wr_csr = wr && (PADDR == `IPN_CSR_OFF);
  wire sw_pop = wr_csr && PWDATA[`IPN_CSR_RESTORE];
  wire [1:0] eff_mask = DEEP_STOP ? 2'b00 : priority_mask;
  // History events feed the sticky status bits
  wire push_full = VEC_FETCH && (hist_cnt == `IPN_HIST_DEPTH);
  wire pop_empty = sw_pop && !VEC_FETCH && (hist_cnt == 3'd0);
  wire [`IPN_EV_W-1:0] ev_set = {VEC_FETCH, pop_empty, push_full};

  // Request building and gating
  always @* begin
    req = SRC_FLAG & SRC_EN;
    // Source 22 comes from the converter flag, not the flag vector
    req[`IPN_CONV_VECTOR] = CONV_DONE_FLAG & conversion_irq_enable;
    next_gated = 40'h00_0000_0000;
    for (i = 0; i < `IPN_SRC_N; i = i + 1) begin
      if (!ctrl_enable)
        next_gated[i] = req[i];
      else
        // All passing requests go out together; the CPU arbitrates
        next_gated[i] = req[i] &&
          (source_priority_level[i*2 +: 2] >= eff_mask);
    end
  end

  // Read mux
  always @* begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (PADDR)
      `IPN_CSR_OFF: begin
        next_rdata[`IPN_CSR_MASK_LSB +: 2] = priority_mask;
        next_rdata[`IPN_CSR_ENABLE] = ctrl_enable;
        next_rdata[`IPN_CSR_FULL] = history_full_flag;
        next_rdata[`IPN_CSR_EMPTY] = history_empty_flag;
        next_rdata[`IPN_CSR_CONV_EN] = conversion_irq_enable;
        next_rdata[`IPN_CSR_CME] = clock_monitor_enable;
        next_rdata[`IPN_CSR_CNT_LSB +: 3] = hist_cnt;
        // Restore strobe is write-only and reads back as zero
      end
      `IPN_HIST_OFF: begin
        next_rdata[7:0] = mask_history_stack;
      end
      `IPN_LVL0_OFF: begin
        next_rdata = source_priority_level[31:0];
      end
      `IPN_LVL1_OFF: begin
        next_rdata = source_priority_level[63:32];
      end
      `IPN_LVL2_OFF: begin
        next_rdata[15:0] = source_priority_level[79:64];
      end
      `IPN_IRQ_STAT_OFF: begin
        next_rdata[`IPN_EV_W-1:0] = irq_status;
      end
      `IPN_IRQ_MASK_OFF: begin
        next_rdata[`IPN_EV_W-1:0] = irq_mask;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // Address match against one register offset; callers gate it with wr
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // APB response: PREADY, PRDATA and PSLVERR all leave from flops
  always @(posedge MCLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      // One wait state keeps PREADY and PRDATA straight from flops
      PREADY <= PSEL & PENABLE & ~PREADY;
      PRDATA <= next_rdata;
      PSLVERR <= PSEL & PENABLE & ~PREADY & next_slverr;
    end
  end

  // Gated requests toward the CPU; one cycle behind the flags
  always @(posedge MCLK) begin
    if (!RST_N) begin
      GATED_REQ <= 40'h00_0000_0000;
    end else begin
      GATED_REQ <= next_gated;
    end
  end

  // Handler location of the vector being fetched
  always @(posedge MCLK) begin
    if (!RST_N) begin
      VEC_ADDR <= 16'h0000;
    end else if (VEC_FETCH) begin
      VEC_ADDR <= vec_loc(VEC_NUM);
    end
  end

  // Reset request is a plain level; the reset unit does the stretching
  always @(posedge MCLK) begin
    if (!RST_N) begin
      RESET_REQ <= 1'b0;
    end else begin
      RESET_REQ <= (|RST_EVENTS) |
        (CLK_LOSS & clock_monitor_enable);
    end
  end

  // Priority mask and its history
  always @(posedge MCLK) begin
    if (!RST_N) begin
      priority_mask <= `IPN_MASK_RST;
      mask_history_stack <= `IPN_HIST_RST;
      hist_cnt <= 3'd0;
      history_full_flag <= 1'b0;
      history_empty_flag <= 1'b1;
    end else if (VEC_FETCH) begin
      // Fetch outranks a same-cycle software restore or mask write
      priority_mask <= level_of(source_priority_level, VEC_NUM);
      // Oldest value falls off the top when already full
      mask_history_stack <= {mask_history_stack[5:0],
        priority_mask};
      if (hist_cnt != `IPN_HIST_DEPTH) begin
        hist_cnt <= hist_cnt + 3'd1;
      end
      history_full_flag <= (hist_cnt >= 3'd3);
      history_empty_flag <= 1'b0;
    end else if (sw_pop) begin
      // A restore on an empty history leaves the mask alone
      if (hist_cnt != 3'd0) begin
        priority_mask <= mask_history_stack[1:0];
        mask_history_stack <= {2'b00, mask_history_stack[7:2]};
        hist_cnt <= hist_cnt - 3'd1;
        history_full_flag <= 1'b0;
        history_empty_flag <= (hist_cnt == 3'd1);
      end
    end else if (wr_csr) begin
      priority_mask <= PWDATA[`IPN_CSR_MASK_LSB +: 2];
    end
  end

  // Control bits written as one word with the mask
  always @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_enable <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_monitor_enable <= 1'b0;
    end else if (wr_csr) begin
      ctrl_enable <= PWDATA[`IPN_CSR_ENABLE];
      conversion_irq_enable <= PWDATA[`IPN_CSR_CONV_EN];
      clock_monitor_enable <= PWDATA[`IPN_CSR_CME];
    end
  end

  // Levels stay writable whatever the nesting depth
  always @(posedge MCLK) begin
    if (!RST_N) begin
      source_priority_level <= `IPN_LVL_RST;
    end else begin
      if (wr && hit(PADDR, `IPN_LVL0_OFF)) begin
        source_priority_level[31:0] <= PWDATA;
      end
      if (wr && hit(PADDR, `IPN_LVL1_OFF)) begin
        source_priority_level[63:32] <= PWDATA;
      end
      if (wr && hit(PADDR, `IPN_LVL2_OFF)) begin
        source_priority_level[79:64] <= PWDATA[15:0];
      end
    end
  end

  // Event status and its mask; IRQ follows one cycle behind
  always @(posedge MCLK) begin
    if (!RST_N) begin
      irq_status <= {`IPN_EV_W{1'b0}};
      irq_mask <= {`IPN_EV_W{1'b0}};
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((irq_status | ev_set) & irq_mask);
      if (wr && hit(PADDR, `IPN_IRQ_MASK_OFF)) begin
        irq_mask <= PWDATA[`IPN_EV_W-1:0];
      end
      // A new event beats a write-one clear in the same cycle
      if (wr && hit(PADDR, `IPN_IRQ_STAT_OFF)) begin
        irq_status <= (irq_status & ~PWDATA[`IPN_EV_W-1:0]) | ev_set;
      end else begin
        irq_status <= irq_status | ev_set;
      end
    end
  end

endmodule // ipn_priority_gate_unit
`default_nettype wire

// [rtl/ipn_regs.vh]
// Register offsets, field positions, reset values and fixed vector figures
// for the interrupt priority gate unit. Definitions only.
`ifndef IPN_REGS_VH
`define IPN_REGS_VH

// Byte offsets on the APB register bus
`define IPN_CSR_OFF 12'h000
`define IPN_HIST_OFF 12'h004
`define IPN_LVL0_OFF 12'h008
`define IPN_LVL1_OFF 12'h00C
`define IPN_LVL2_OFF 12'h010
`define IPN_IRQ_STAT_OFF 12'h014
`define IPN_IRQ_MASK_OFF 12'h018

// priority_ctrl_status fields
`define IPN_CSR_MASK_LSB 0
`define IPN_CSR_RESTORE 2
`define IPN_CSR_ENABLE 3
`define IPN_CSR_FULL 4
`define IPN_CSR_EMPTY 5
`define IPN_CSR_CONV_EN 6
`define IPN_CSR_CME 7
`define IPN_CSR_CNT_LSB 8

// Interrupt status bits
`define IPN_EV_OVERFLOW 0
`define IPN_EV_UNDERFLOW 1
`define IPN_EV_FETCH 2
`define IPN_EV_W 3

// Sources are indexed by vector number
`define IPN_SRC_N 40
`define IPN_LVL_PER_WORD 16
`define IPN_HIST_DEPTH 3'd4
`define IPN_CONV_VECTOR 22
`define IPN_VEC_TOP 16'hFFFE

// Reset values
`define IPN_MASK_RST 2'b00
`define IPN_LVL_RST 80'h0
`define IPN_HIST_RST 8'h00

`endif

// [test/ipn_gate_props.sv]
// Port checker for the priority gate unit, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ipn_gate_props (
  input wire logic MCLK, RST_N, PSEL, PENABLE, PREADY, DEEP_STOP,
  input wire logic VEC_FETCH, CONV_DONE_FLAG, CLK_LOSS, RESET_REQ,
  input wire logic [39:0] SRC_FLAG, SRC_EN, GATED_REQ,
  input wire logic [5:0] VEC_NUM,
  input wire logic [15:0] VEC_ADDR,
  input wire logic [6:0] RST_EVENTS
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_en; GATED_REQ[5] |-> $past(SRC_FLAG[5] & SRC_EN[5]); endproperty
  a_en: assert property (p_en) else $error("unenabled request");
  property p_cv; GATED_REQ[22] |-> $past(CONV_DONE_FLAG); endproperty
  a_cv: assert property (p_cv) else $error("stray vector 22");
  property p_st; DEEP_STOP & SRC_FLAG[5] & SRC_EN[5] |=> GATED_REQ[5];
  endproperty
  a_st: assert property (p_st) else $error("stop gating");
  property p_no; SRC_FLAG == 40'h0 && !CONV_DONE_FLAG |=> GATED_REQ == 40'h0;
  endproperty
  a_no: assert property (p_no) else $error("request from nothing");
  property p_va;
    VEC_FETCH |=> VEC_ADDR == 16'hFFFE - {9'h000, $past(VEC_NUM), 1'b0};
  endproperty
  a_va: assert property (p_va) else $error("vector address");
  property p_rr; |RST_EVENTS |=> RESET_REQ; endproperty
  a_rr: assert property (p_rr) else $error("reset missed");
  property p_rc; RESET_REQ |-> $past(|RST_EVENTS | CLK_LOSS); endproperty
  a_rc: assert property (p_rc) else $error("reset uncaused");
endmodule // ipn_gate_props
bind ipn_priority_gate_unit ipn_gate_props i_props (.*);
`default_nettype wire

// [test/ipn_cpu_model.sv]
// CPU stand-in: on go, fetches the lowest pending gated vector.
// Lower numbers win, as in the core's fixed arbitration.
`timescale 1ns/1ps
`default_nettype none
module ipn_cpu_model (
  input wire logic clk, go,
  input wire logic [39:0] req,
  output var logic fetch = 1'b0,
  output var logic [5:0] num = 6'h00
);
  always @(posedge clk) begin
    fetch <= go && |req;
    num <= ~num;
    for (int i = 39; i >= 0; i--) if (go && req[i]) num <= 6'(i);
  end
endmodule // ipn_cpu_model
`default_nettype wire

// [test/interrupt_priority_nesting_test.sv]
// Bench for the priority gate unit: APB task and a CPU stand-in.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
`include "ipn_regs.vh"
module interrupt_priority_nesting_test;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, conv = 1'b0, stop = 1'b0, go = 1'b0, loss = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [39:0] flag = 40'h0, en = 40'hFF_FFFF_FDFF;
  logic [6:0] rev = 7'h00;
  wire [31:0] prdata;
  wire pready, pslverr, fetch, irq, rreq;
  wire [5:0] vnum;
  wire [39:0] greq;
  wire [15:0] vaddr;
  int err_total = 0, n_tests = 0, cyc = 0;
  always #10 mclk = ~mclk;
  ipn_priority_gate_unit i_dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SRC_FLAG(flag),
    .SRC_EN(en), .CONV_DONE_FLAG(conv), .DEEP_STOP(stop), .VEC_FETCH(fetch),
    .VEC_NUM(vnum), .GATED_REQ(greq), .VEC_ADDR(vaddr), .CLK_LOSS(loss),
    .RST_EVENTS(rev), .RESET_REQ(rreq), .IRQ(irq));
  ipn_cpu_model i_cpu (.clk(mclk), .go(go), .req(greq), .fetch(fetch),
    .num(vnum));
  task automatic chk(input logic [39:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Reads compare with d; offsets past the last register must be refused
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    tick(1);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    tick(1);
    penable <= 1'b1;
    do tick(1); while (pready !== 1'b1);
    if (!w) chk(prdata, d);
    chk(pslverr, a > `IPN_IRQ_MASK_OFF);
    {psel, penable} <= 2'b00;
  endtask
  task automatic take;
    tick(2);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(3);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results;
    end
  end
  initial begin
    tick(20);
    rst_n <= 1'b1;
    apb(1'b0, `IPN_CSR_OFF, 32'h0000_0020);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    flag <= 40'h00_0000_02E0;
    apb(1'b1, `IPN_LVL0_OFF, 32'h0000_D800);
    apb(1'b0, `IPN_LVL0_OFF, 32'h0000_D800);
    apb(1'b1, `IPN_CSR_OFF, 32'h0000_000A);
    apb(1'b0, `IPN_CSR_OFF, 32'h0000_002A);
    chk(greq, 40'h00_0000_00A0);
    stop <= 1'b1;
    tick(3);
    chk(greq, 40'h00_0000_00E0);
    {stop, conv} <= 2'b01;
    apb(1'b1, `IPN_CSR_OFF, 32'h0000_0042);
    tick(2);
    chk(greq, 40'h00_0040_00E0);
    {conv, loss, rev} <= {2'b01, 7'h40};
    apb(1'b1, `IPN_CSR_OFF, 32'h0000_0088);
    rev <= 7'h00;
    tick(3);
    chk(rreq, 1'b1);
    $display("test gating done");
    apb(1'b1, `IPN_IRQ_MASK_OFF, 32'h0000_0001);
    take;
    chk(vaddr, 16'hFFF4);
    chk(irq, 1'b0);
    flag[5] <= 1'b0;
    repeat (3) take;
    apb(1'b0, `IPN_CSR_OFF, 32'h0000_049B);
    apb(1'b0, `IPN_HIST_OFF, 32'h0000_002F);
    take;
    apb(1'b0, `IPN_HIST_OFF, 32'h0000_00BF);
    chk(irq, 1'b1);
    repeat (5) apb(1'b1, `IPN_CSR_OFF, 32'h0000_008C);
    apb(1'b0, `IPN_CSR_OFF, 32'h0000_00AA);
    apb(1'b0, `IPN_IRQ_STAT_OFF, 32'h0000_0007);
    apb(1'b1, `IPN_IRQ_STAT_OFF, 32'h0000_0007);
    tick(2);
    chk(irq, 1'b0);
    $display("test nesting done");
    results;
  end
endmodule // interrupt_priority_nesting_test
`default_nettype wire
